// ---- verilog/aes_pkg.sv ----
// constants, field layout and types of the alarm and event supervisor
package aes_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int MEAS_W = 16;
   localparam int NUM_EV = 5;
   localparam int NUM_ALM = 8;
   localparam int NUM_PIN = 5;
   localparam int CNT_W = 32;

   // register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_ALARM = 8'h08;
   localparam logic [7:0] OFS_EVT_STAT = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_STATE = 8'h18;
   localparam logic [7:0] OFS_OVP_THR = 8'h20;
   localparam logic [7:0] OFS_OCP_THR = 8'h24;
   localparam logic [7:0] OFS_OPP_THR = 8'h28;
   localparam logic [7:0] OFS_EVT_ACTION = 8'h2C;
   localparam logic [7:0] OFS_EVT_THR0 = 8'h30;
   localparam logic [7:0] OFS_EVT_THR_STEP = 8'h04;

   // control register fields
   localparam int CTRL_SOUND = 0;
   localparam int CTRL_MASTER = 1;
   localparam int CTRL_PF_RESUME = 2;
   localparam int CTRL_OT_RESUME = 3;
   localparam int CTRL_W = 4;
   // command register fields (write-only pulses)
   localparam int CMD_ON = 0;
   localparam int CMD_OFF = 1;
   localparam int CMD_REINIT = 2;
   localparam int CMD_RECALL = 3;
   localparam int CMD_DISMISS = 4;
   // alarm bits
   localparam int ALM_OVP = 0;
   localparam int ALM_OCP = 1;
   localparam int ALM_OPP = 2;
   localparam int ALM_PF = 3;
   localparam int ALM_OT = 4;
   localparam int ALM_MSP = 5;
   localparam int ALM_SF = 6;
   localparam int ALM_USER = 7;
   // event indices
   localparam int EV_UV = 0;
   localparam int EV_OV = 1;
   localparam int EV_UC = 2;
   localparam int EV_OC = 3;
   localparam int EV_OP = 4;
   localparam logic [NUM_EV-1:0] EV_UNDER_MASK = 5'h05;
   localparam int EVT_WARN_POS = 8;
   // hardware alarm pins
   localparam int PIN_AC_FAULT = 0;
   localparam int PIN_OVERTEMP = 1;
   localparam int PIN_SLAVE_LOST = 2;
   localparam int PIN_SHARE_FAULT = 3;
   localparam int PIN_SHARE_WIRED = 4;
   // interrupt bits
   localparam int IRQ_ALARM = 0;
   localparam int IRQ_WARN = 1;
   localparam int IRQ_SIGNAL = 2;
   localparam int IRQ_W = 3;

   // reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h1;
   localparam logic [MEAS_W-1:0] THR_RST = 16'hFFFF;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

   // timing
   localparam longint CLK_HZ = 100000000;
   localparam longint PF_ACK_MS = 1000;
   localparam longint PF_RESTART_MS = 5000;
   localparam logic [CNT_W-1:0] PF_ACK_CYC = CNT_W'(CLK_HZ / 1000 * PF_ACK_MS);
   localparam logic [CNT_W-1:0] PF_RESTART_CYC = CNT_W'(CLK_HZ / 1000 * PF_RESTART_MS);

   typedef enum logic [1:0]
   {
      ACT_NONE = 2'h0,
      ACT_SIGNAL = 2'h1,
      ACT_WARNING = 2'h2,
      ACT_ALARM = 2'h3
   } aes_action_t;

   typedef enum logic [1:0]
   {
      DC_OFF = 2'h0,
      DC_ON = 2'h1,
      DC_HOLD = 2'h2
   } aes_dc_state_t;
endpackage : aes_pkg

// ---- verilog/aes_evt_if.sv ----
// link between the supervisor and one user event comparator
`timescale 1ns/1ps
interface aes_evt_if;
   logic [aes_pkg::MEAS_W-1:0] value;
   logic [aes_pkg::MEAS_W-1:0] threshold;
   logic under;
   aes_pkg::aes_action_t action;
   logic armed;
   logic hit;
   logic rise;
   modport unit (input value, input threshold, input under, input action, input armed,
      output hit, output rise);
   modport host (output value, output threshold, output under, output action, output armed,
      input hit, input rise);
endinterface : aes_evt_if

// ---- verilog/aes_event_unit.sv ----
// one user event: threshold compare, gating and rising edge
`timescale 1ns/1ps
module aes_event_unit
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   // event link
   aes_evt_if.unit ev
);
   logic cond;
   logic hit_reg;
   logic hit_next;

   always_comb
   begin
      if (ev.under)
      begin
         cond = ev.value < ev.threshold;
      end
      else
      begin
         cond = ev.value > ev.threshold;
      end
      hit_next = cond && ev.armed && (ev.action != aes_pkg::ACT_NONE); // R1 R18
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         hit_reg <= 1'b0;
      end
      else if (ce_in)
      begin
         hit_reg <= hit_next;
      end
   end

   assign ev.hit = hit_reg;
   assign ev.rise = hit_next && !hit_reg;
endmodule : aes_event_unit

// ---- verilog/aes_supervisor.sv ----
// alarm and user event supervisor with register port and dc input control
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps

// Notes on behaviour
// R1 - action none: event fully ignored
// R2 - signal: status text only
// R3 - warning: text, popup, held until acknowledged
// R4 - alarm: text, popup, sound, dc off
// R5 - alarms readable; most on analog output
// R6 - device alarm: dc off, popup, sound
// R7 - alarms latched until explicit acknowledge
// R8 - dismissed popup recallable while alarm pending
// R9 - voltage at threshold raises alarm, dc off
// R10 - power at threshold raises alarm, dc off
// R11 - current at threshold raises alarm, dc off
// R12 - supply fault alarm; resume setting selectable
// R13 - supply alarm ack one second after clear
// R14 - five second wait before dc on
// R15 - overtemperature alarm; resume setting selectable
// R16 - master: slave loss alarm, cleared by reinit
// R17 - share fault or stray wiring alarm
// R18 - events only while dc on; default none
// R19 - five independent threshold detection events
module aes_supervisor
#(
   parameter logic [aes_pkg::CNT_W-1:0] PF_ACK_CYC = aes_pkg::PF_ACK_CYC,
   parameter logic [aes_pkg::CNT_W-1:0] PF_RESTART_CYC = aes_pkg::PF_RESTART_CYC
)
(
   // clock, reset, enable
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   // register port
   input wire logic [aes_pkg::ADDR_W-1:0] addr_in,
   input wire logic [aes_pkg::DATA_W-1:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   output logic [aes_pkg::DATA_W-1:0] rd_data_out,
   // measurement path
   input wire logic [aes_pkg::MEAS_W-1:0] meas_voltage_in,
   input wire logic [aes_pkg::MEAS_W-1:0] meas_current_in,
   input wire logic [aes_pkg::MEAS_W-1:0] meas_power_in,
   // hardware alarm pins
   input wire logic ac_fault_in,
   input wire logic overtemp_in,
   input wire logic slave_lost_in,
   input wire logic share_fault_in,
   input wire logic share_wired_in,
   // power stage and indications
   output logic dc_enable_out,
   output logic popup_alarm_out,
   output logic popup_warning_out,
   output logic buzzer_out,
   output logic analog_alarm_out,
   output logic [aes_pkg::NUM_EV-1:0] status_text_out,
   output logic irq_out
);
   // register file
   logic [aes_pkg::CTRL_W-1:0] ctrl_reg;
   logic [aes_pkg::MEAS_W-1:0] ovp_thr_reg;
   logic [aes_pkg::MEAS_W-1:0] ocp_thr_reg;
   logic [aes_pkg::MEAS_W-1:0] opp_thr_reg;
   logic [aes_pkg::MEAS_W-1:0] ev_thr_reg [aes_pkg::NUM_EV];
   aes_pkg::aes_action_t ev_act_reg [aes_pkg::NUM_EV];
   logic [aes_pkg::IRQ_W-1:0] irq_stat_reg;
   logic [aes_pkg::IRQ_W-1:0] irq_mask_reg;
   logic [aes_pkg::NUM_ALM-1:0] alarm_reg;
   logic [aes_pkg::NUM_EV-1:0] warn_reg;
   logic popup_reg;
   aes_pkg::aes_dc_state_t dc_state_reg;
   logic [aes_pkg::CNT_W-1:0] ack_cnt_reg;
   logic [aes_pkg::CNT_W-1:0] restart_cnt_reg;
   logic pf_resume_reg;
   logic ot_resume_reg;

   // pin synchronisers
   logic [aes_pkg::NUM_PIN-1:0] pins;
   logic [aes_pkg::NUM_PIN-1:0] pin_s1_reg;
   logic [aes_pkg::NUM_PIN-1:0] pin_s2_reg;
   logic [aes_pkg::NUM_PIN-1:0] pin_s3_reg;
   logic [aes_pkg::NUM_PIN-1:0] pin_reg;

   // combinational terms
   logic wr_ctrl;
   logic wr_cmd;
   logic wr_alarm;
   logic wr_evt;
   logic wr_irq_stat;
   logic [aes_pkg::NUM_ALM-1:0] alarm_cond;
   logic [aes_pkg::NUM_ALM-1:0] alarm_ack;
   logic [aes_pkg::NUM_ALM-1:0] alarm_next;
   logic [aes_pkg::NUM_EV-1:0] ev_hit;
   logic [aes_pkg::NUM_EV-1:0] ev_rise;
   logic [aes_pkg::NUM_EV-1:0] sig_live;
   logic [aes_pkg::NUM_EV-1:0] warn_next;
   logic [aes_pkg::NUM_EV-1:0] warn_rise;
   logic [aes_pkg::NUM_EV-1:0] sig_rise;
   logic user_alarm;
   logic alarm_rise;
   logic pf_ack_ok;
   logic on_allowed;
   logic dc_on;
   logic [aes_pkg::IRQ_W-1:0] irq_next;
   logic [aes_pkg::DATA_W-1:0] rd_next;
   logic master;

   assign master = ctrl_reg[aes_pkg::CTRL_MASTER];
   assign dc_on = (dc_state_reg == aes_pkg::DC_ON);
   assign wr_ctrl = wr_en_in && (addr_in == aes_pkg::OFS_CTRL);
   assign wr_cmd = wr_en_in && (addr_in == aes_pkg::OFS_CMD);
   assign wr_alarm = wr_en_in && (addr_in == aes_pkg::OFS_ALARM);
   assign wr_evt = wr_en_in && (addr_in == aes_pkg::OFS_EVT_STAT);
   assign wr_irq_stat = wr_en_in && (addr_in == aes_pkg::OFS_IRQ_STAT);

   assign pins = {share_wired_in, share_fault_in, slave_lost_in, overtemp_in, ac_fault_in};

   // three stages; a change is taken once stages two and three agree
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         pin_s3_reg <= '0;
         pin_reg <= '0;
      end
      else if (ce_in)
      begin
         pin_s1_reg <= pins;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         pin_reg <= (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg | pin_s3_reg));
      end
   end

   // user event comparators
   generate
      for (genvar i = 0; i < aes_pkg::NUM_EV; i++)
      begin : g_ev
         aes_evt_if ev_link ();
         assign ev_link.value = (i == aes_pkg::EV_UV || i == aes_pkg::EV_OV) ? meas_voltage_in :
            (i == aes_pkg::EV_OP) ? meas_power_in : meas_current_in; // R19
         assign ev_link.threshold = ev_thr_reg[i];
         assign ev_link.under = aes_pkg::EV_UNDER_MASK[i];
         assign ev_link.action = ev_act_reg[i];
         assign ev_link.armed = dc_on; // R18
         assign ev_hit[i] = ev_link.hit;
         assign ev_rise[i] = ev_link.rise;
         aes_event_unit u_event
         (
            .clk_sys_in(clk_sys_in),
            .arst_n_in(arst_n_in),
            .ce_in(ce_in),
            .ev(ev_link.unit)
         );
      end
   endgenerate

   always_comb
   begin
      user_alarm = 1'b0;
      for (int i = 0; i < aes_pkg::NUM_EV; i++)
      begin
         sig_live[i] = ev_hit[i] && (ev_act_reg[i] != aes_pkg::ACT_NONE); // R2
         sig_rise[i] = ev_rise[i] && (ev_act_reg[i] == aes_pkg::ACT_SIGNAL);
         warn_rise[i] = ev_rise[i] && (ev_act_reg[i] == aes_pkg::ACT_WARNING); // R3
         if (ev_hit[i] && ev_act_reg[i] == aes_pkg::ACT_ALARM)
         begin
            user_alarm = 1'b1; // R4
         end
      end
   end

   // alarm causes
   always_comb
   begin
      alarm_cond = '0;
      alarm_cond[aes_pkg::ALM_OVP] = meas_voltage_in >= ovp_thr_reg; // R9
      alarm_cond[aes_pkg::ALM_OCP] = meas_current_in >= ocp_thr_reg; // R11
      alarm_cond[aes_pkg::ALM_OPP] = meas_power_in >= opp_thr_reg; // R10
      alarm_cond[aes_pkg::ALM_PF] = pin_reg[aes_pkg::PIN_AC_FAULT]; // R12
      alarm_cond[aes_pkg::ALM_OT] = pin_reg[aes_pkg::PIN_OVERTEMP]; // R15
      alarm_cond[aes_pkg::ALM_MSP] = master && pin_reg[aes_pkg::PIN_SLAVE_LOST]; // R16
      alarm_cond[aes_pkg::ALM_SF] = pin_reg[aes_pkg::PIN_SHARE_FAULT] ||
         (pin_reg[aes_pkg::PIN_SHARE_WIRED] && !master); // R17
      alarm_cond[aes_pkg::ALM_USER] = user_alarm;
   end

   assign pf_ack_ok = (ack_cnt_reg >= PF_ACK_CYC);

   // acknowledge; set wins over clear
   always_comb
   begin
      alarm_ack = wr_alarm ? wr_data_in[aes_pkg::NUM_ALM-1:0] : '0;
      alarm_ack[aes_pkg::ALM_PF] = alarm_ack[aes_pkg::ALM_PF] && pf_ack_ok; // R13
      alarm_ack[aes_pkg::ALM_MSP] = wr_cmd && wr_data_in[aes_pkg::CMD_REINIT]; // R16
      alarm_next = (alarm_reg & ~alarm_ack) | alarm_cond; // R7
      alarm_rise = |(alarm_cond & ~alarm_reg);
      warn_next = (warn_reg & ~(wr_evt ? wr_data_in[aes_pkg::EVT_WARN_POS +:
         aes_pkg::NUM_EV] : '0)) | warn_rise; // R3 R7
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         alarm_reg <= '0;
         warn_reg <= '0;
      end
      else if (ce_in)
      begin
         alarm_reg <= alarm_next;
         warn_reg <= warn_next;
      end
   end

   // supply fault timers: ack delay and restart lock
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ack_cnt_reg <= '0;
         restart_cnt_reg <= '0;
      end
      else if (ce_in)
      begin
         if (alarm_cond[aes_pkg::ALM_PF])
         begin
            ack_cnt_reg <= '0; // R13
            restart_cnt_reg <= PF_RESTART_CYC; // R14
         end
         else
         begin
            if (!pf_ack_ok)
            begin
               ack_cnt_reg <= ack_cnt_reg + 1'b1;
            end
            if (restart_cnt_reg != '0)
            begin
               restart_cnt_reg <= restart_cnt_reg - 1'b1;
            end
         end
      end
   end

   assign on_allowed = (alarm_reg == '0) && (alarm_cond == '0) && (restart_cnt_reg == '0);

   // dc input state
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         dc_state_reg <= aes_pkg::DC_OFF;
         pf_resume_reg <= 1'b0;
         ot_resume_reg <= 1'b0;
      end
      else if (ce_in)
      begin
         if (alarm_cond[aes_pkg::ALM_PF] && dc_on)
         begin
            pf_resume_reg <= ctrl_reg[aes_pkg::CTRL_PF_RESUME]; // R12
         end
         if (alarm_cond[aes_pkg::ALM_OT] && dc_on)
         begin
            ot_resume_reg <= ctrl_reg[aes_pkg::CTRL_OT_RESUME]; // R15
         end
         case (dc_state_reg)
            aes_pkg::DC_OFF:
            begin
               if (wr_cmd && wr_data_in[aes_pkg::CMD_ON] && on_allowed)
               begin
                  dc_state_reg <= aes_pkg::DC_ON;
               end
               else if (pf_resume_reg || ot_resume_reg)
               begin
                  dc_state_reg <= aes_pkg::DC_HOLD;
               end
            end
            aes_pkg::DC_ON:
            begin
               if (alarm_cond != '0)
               begin
                  dc_state_reg <= aes_pkg::DC_OFF; // R4 R6 R9 R10 R11 R12 R15 R16
               end
               else if (wr_cmd && wr_data_in[aes_pkg::CMD_OFF])
               begin
                  dc_state_reg <= aes_pkg::DC_OFF;
               end
            end
            aes_pkg::DC_HOLD:
            begin
               if (wr_cmd && wr_data_in[aes_pkg::CMD_OFF])
               begin
                  dc_state_reg <= aes_pkg::DC_OFF;
                  pf_resume_reg <= 1'b0;
                  ot_resume_reg <= 1'b0;
               end
               else if (alarm_cond == '0 && restart_cnt_reg == '0) // R14
               begin
                  dc_state_reg <= aes_pkg::DC_ON;
                  pf_resume_reg <= 1'b0;
                  ot_resume_reg <= 1'b0;
               end
            end
            default:
            begin
               dc_state_reg <= aes_pkg::DC_OFF;
            end
         endcase
      end
   end

   // popup: raised on new alarm or warning, dismiss and recall by command
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         popup_reg <= 1'b0;
      end
      else if (ce_in)
      begin
         if (alarm_rise || (|warn_rise))
         begin
            popup_reg <= 1'b1; // R3 R4 R6
         end
         else if (alarm_next == '0 && warn_next == '0)
         begin
            popup_reg <= 1'b0;
         end
         else if (wr_cmd && wr_data_in[aes_pkg::CMD_RECALL])
         begin
            popup_reg <= 1'b1; // R8
         end
         else if (wr_cmd && wr_data_in[aes_pkg::CMD_DISMISS])
         begin
            popup_reg <= 1'b0;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ctrl_reg <= aes_pkg::CTRL_RST;
         ovp_thr_reg <= aes_pkg::THR_RST;
         ocp_thr_reg <= aes_pkg::THR_RST;
         opp_thr_reg <= aes_pkg::THR_RST;
         irq_mask_reg <= aes_pkg::IRQ_MASK_RST;
         for (int i = 0; i < aes_pkg::NUM_EV; i++)
         begin
            ev_thr_reg[i] <= aes_pkg::THR_RST;
            ev_act_reg[i] <= aes_pkg::ACT_NONE; // R18
         end
      end
      else if (ce_in && wr_en_in)
      begin
         if (wr_ctrl)
         begin
            ctrl_reg <= wr_data_in[aes_pkg::CTRL_W-1:0];
         end
         if (addr_in == aes_pkg::OFS_OVP_THR)
         begin
            ovp_thr_reg <= wr_data_in;
         end
         if (addr_in == aes_pkg::OFS_OCP_THR)
         begin
            ocp_thr_reg <= wr_data_in;
         end
         if (addr_in == aes_pkg::OFS_OPP_THR)
         begin
            opp_thr_reg <= wr_data_in;
         end
         if (addr_in == aes_pkg::OFS_IRQ_MASK)
         begin
            irq_mask_reg <= wr_data_in[aes_pkg::IRQ_W-1:0];
         end
         for (int i = 0; i < aes_pkg::NUM_EV; i++)
         begin
            if (addr_in == aes_pkg::OFS_EVT_ACTION)
            begin
               ev_act_reg[i] <= aes_pkg::aes_action_t'(wr_data_in[2*i +: 2]);
            end
            if (addr_in == aes_pkg::OFS_EVT_THR0 + 8'(i) * aes_pkg::OFS_EVT_THR_STEP)
            begin
               ev_thr_reg[i] <= wr_data_in;
            end
         end
      end
   end

   // interrupt status, write one to clear, set wins
   always_comb
   begin
      irq_next = irq_stat_reg & ~(wr_irq_stat ? wr_data_in[aes_pkg::IRQ_W-1:0] : '0);
      irq_next[aes_pkg::IRQ_ALARM] = irq_next[aes_pkg::IRQ_ALARM] | alarm_rise;
      irq_next[aes_pkg::IRQ_WARN] = irq_next[aes_pkg::IRQ_WARN] | (|warn_rise);
      irq_next[aes_pkg::IRQ_SIGNAL] = irq_next[aes_pkg::IRQ_SIGNAL] | (|sig_rise);
   end

   // read mux
   always_comb
   begin
      rd_next = '0;
      case (addr_in)
         aes_pkg::OFS_CTRL: rd_next[aes_pkg::CTRL_W-1:0] = ctrl_reg;
         aes_pkg::OFS_ALARM: rd_next[aes_pkg::NUM_ALM-1:0] = alarm_reg; // R5
         aes_pkg::OFS_EVT_STAT:
         begin
            rd_next[aes_pkg::NUM_EV-1:0] = sig_live;
            rd_next[aes_pkg::EVT_WARN_POS +: aes_pkg::NUM_EV] = warn_reg;
         end
         aes_pkg::OFS_IRQ_STAT: rd_next[aes_pkg::IRQ_W-1:0] = irq_stat_reg;
         aes_pkg::OFS_IRQ_MASK: rd_next[aes_pkg::IRQ_W-1:0] = irq_mask_reg;
         aes_pkg::OFS_STATE:
         begin
            rd_next[1:0] = dc_state_reg;
            rd_next[2] = popup_reg;
            rd_next[3] = pf_ack_ok;
            rd_next[4] = (restart_cnt_reg != '0);
         end
         aes_pkg::OFS_OVP_THR: rd_next = ovp_thr_reg;
         aes_pkg::OFS_OCP_THR: rd_next = ocp_thr_reg;
         aes_pkg::OFS_OPP_THR: rd_next = opp_thr_reg;
         aes_pkg::OFS_EVT_ACTION:
         begin
            for (int i = 0; i < aes_pkg::NUM_EV; i++)
            begin
               rd_next[2*i +: 2] = ev_act_reg[i];
            end
         end
         default:
         begin
            for (int i = 0; i < aes_pkg::NUM_EV; i++)
            begin
               if (addr_in == aes_pkg::OFS_EVT_THR0 + 8'(i) * aes_pkg::OFS_EVT_THR_STEP)
               begin
                  rd_next = ev_thr_reg[i];
               end
            end
         end
      endcase
   end

   // registered outputs
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         irq_stat_reg <= '0;
         rd_data_out <= '0;
         dc_enable_out <= 1'b0;
         popup_alarm_out <= 1'b0;
         popup_warning_out <= 1'b0;
         buzzer_out <= 1'b0;
         analog_alarm_out <= 1'b0;
         status_text_out <= '0;
         irq_out <= 1'b0;
      end
      else if (ce_in)
      begin
         irq_stat_reg <= irq_next;
         rd_data_out <= rd_en_in ? rd_next : '0;
         dc_enable_out <= dc_on && (alarm_cond == '0); // R6
         popup_alarm_out <= popup_reg && (alarm_reg != '0); // R6
         popup_warning_out <= popup_reg && (alarm_reg == '0) && (warn_reg != '0);
         buzzer_out <= ctrl_reg[aes_pkg::CTRL_SOUND] && popup_reg && (alarm_reg != '0); // R4
         analog_alarm_out <= |alarm_reg[aes_pkg::ALM_OT:aes_pkg::ALM_OVP]; // R5
         status_text_out <= sig_live; // R2
         irq_out <= |(irq_stat_reg & irq_mask_reg);
      end
   end
endmodule : aes_supervisor

// ---- tb/aes_supervisor_assertions.sv ----
// port checker of the alarm and event supervisor
`timescale 1ns/1ps
module aes_sup_chk
(
   // watched ports
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic rd_en_in,
   input wire logic [aes_pkg::DATA_W-1:0] rd_data_out,
   input wire logic ac_fault_in,
   input wire logic overtemp_in,
   input wire logic dc_enable_out,
   input wire logic popup_alarm_out,
   input wire logic popup_warning_out,
   input wire logic buzzer_out,
   input wire logic analog_alarm_out,
   input wire logic irq_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);
   rd_idle_a: assert property (!$past(rd_en_in) |-> rd_data_out == 16'h0000)
      else $error("read data not idle");
   pf_off_a: assert property (ac_fault_in [*8] |-> !dc_enable_out)
      else $error("dc on during supply fault");
   ot_off_a: assert property (overtemp_in [*8] |-> !dc_enable_out)
      else $error("dc on during overtemperature");
   buzz_popup_a: assert property (buzzer_out |-> popup_alarm_out)
      else $error("sound without alarm popup");
   popup_excl_a: assert property (!(popup_alarm_out && popup_warning_out))
      else $error("both popups shown");
   analog_off_a: assert property ($rose(analog_alarm_out) |-> !dc_enable_out)
      else $error("analog alarm with dc on");
   warn_keep_a: assert property ($rose(popup_warning_out) |-> $stable(dc_enable_out))
      else $error("warning changed dc state");
   rst_quiet_a: assert property ($rose(arst_n_in) |-> !dc_enable_out && !irq_out)
      else $error("outputs active after reset");
   cover property ($rose(buzzer_out));
   cover property ($rose(popup_warning_out));
   cover property ($rose(irq_out));
endmodule : aes_sup_chk
bind aes_supervisor aes_sup_chk u_chk (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
   .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .ac_fault_in(ac_fault_in),
   .overtemp_in(overtemp_in), .dc_enable_out(dc_enable_out),
   .popup_alarm_out(popup_alarm_out), .popup_warning_out(popup_warning_out),
   .buzzer_out(buzzer_out), .analog_alarm_out(analog_alarm_out), .irq_out(irq_out));

// ---- tb/aes_host_model.sv ----
// register bus master standing in for panel and remote interfaces
`timescale 1ns/1ps
module aes_host_model
(
   // clock
   input wire logic clk_sys_in,
   // register bus
   output logic [7:0] addr_out = 8'h00,
   output logic [15:0] wr_data_out = 16'h0000,
   output logic wr_en_out = 1'b0,
   output logic rd_en_out = 1'b0,
   input wire logic [15:0] rd_data_in
);
   task wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk_sys_in);
      addr_out <= a;
      wr_data_out <= v;
      wr_en_out <= 1'b1;
      @(posedge clk_sys_in);
      wr_en_out <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk_sys_in);
      addr_out <= a;
      rd_en_out <= 1'b1;
      @(posedge clk_sys_in);
      rd_en_out <= 1'b0;
      @(posedge clk_sys_in);
      v = rd_data_in;
   endtask : rd
endmodule : aes_host_model

// ---- tb/aes_supervisor_tb.sv ----
// testbench of the alarm and event supervisor
`timescale 1ns/1ps
module aes_supervisor_tb;
   logic clk_sys_in = 1'b0, arst_n_in = 1'b0;
   logic [15:0] meas [3] = '{default: 16'h0000};
   logic [4:0] hw = 5'h00;
   logic [7:0] addr;
   logic [15:0] wdat, rdat, d;
   logic wr, rd, dc, pa, pw, bz, an, irq;
   logic [4:0] st;
   int mismatches = 0, cmp_count = 0;
   always #5 clk_sys_in = ~clk_sys_in;
   aes_host_model u_host (.clk_sys_in(clk_sys_in), .addr_out(addr), .wr_data_out(wdat),
      .wr_en_out(wr), .rd_en_out(rd), .rd_data_in(rdat));
   aes_supervisor #(.PF_ACK_CYC(32'h14), .PF_RESTART_CYC(32'hC8)) u_dut (
      .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .ce_in(1'b1), .addr_in(addr),
      .wr_data_in(wdat), .wr_en_in(wr), .rd_en_in(rd), .rd_data_out(rdat),
      .meas_voltage_in(meas[0]), .meas_current_in(meas[1]), .meas_power_in(meas[2]),
      .ac_fault_in(hw[0]), .overtemp_in(hw[1]), .slave_lost_in(hw[2]),
      .share_fault_in(hw[3]), .share_wired_in(hw[4]), .dc_enable_out(dc),
      .popup_alarm_out(pa), .popup_warning_out(pw), .buzzer_out(bz),
      .analog_alarm_out(an), .status_text_out(st), .irq_out(irq));
   task chk(input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e)
      begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask : cyc
   task rdchk(input logic [7:0] a, input logic [15:0] e);
      u_host.rd(a, d);
      chk(d, e);
   endtask : rdchk
   task t_prot;
      for (int i = 0; i < 3; i++)
      begin
         u_host.wr(8'h20 + 8'(4 * i), 16'h0100);
         u_host.wr(8'h04, 16'h0001);
         cyc(4);
         chk(16'(dc), 16'h0001);
         @(posedge clk_sys_in) meas[i] <= 16'h0100;
         u_host.wr(8'h04, 16'h0010);
         rdchk(8'h18, 16'h0008);
         u_host.wr(8'h04, 16'h0008);
         cyc(4);
         chk(16'({dc, pa, bz, an, irq}), 16'h000E);
         @(posedge clk_sys_in) meas[i] <= 16'h0000;
         u_host.wr(8'h20 + 8'(4 * i), 16'hFFFF);
         rdchk(8'h08, 16'(1 << i));
         u_host.wr(8'h08, 16'h00FF);
         u_host.wr(8'h10, 16'h0007);
         rdchk(8'h08, 16'h0000);
      end
   endtask : t_prot
   task t_evt;
      u_host.wr(8'h14, 16'h0007);
      u_host.wr(8'h34, 16'h0100);
      for (int a = 0; a < 4; a++)
      begin
         u_host.wr(8'h2C, 16'(a << 2));
         @(posedge clk_sys_in) meas[0] <= 16'h0200;
         cyc(4);
         chk(16'(st), 16'h0000);
         u_host.wr(8'h04, 16'h0001);
         cyc(6);
         chk(16'({st, pw, pa, dc, irq}), 16'({(a == 1 || a == 2) ? 5'h02 : 5'h00,
            a == 2, a == 3, a != 3, a != 0}));
         rdchk(8'h0C, 16'(((a == 2) << 9) | ((a == 1 || a == 2) << 1)));
         @(posedge clk_sys_in) meas[0] <= 16'h0000;
         u_host.wr(8'h08, 16'h00FF);
         u_host.wr(8'h0C, 16'h1F00);
         u_host.wr(8'h10, 16'h0007);
         u_host.wr(8'h04, 16'h0002);
         cyc(3);
         chk(16'({irq, pa, pw}), 16'h0000);
      end
   endtask : t_evt
   task t_pf;
      u_host.wr(8'h00, 16'h0005);
      u_host.wr(8'h04, 16'h0001);
      @(posedge clk_sys_in) hw[0] <= 1'b1;
      cyc(10);
      chk(16'({dc, an}), 16'h0001);
      rdchk(8'h08, 16'h0008);
      @(posedge clk_sys_in) hw[0] <= 1'b0;
      cyc(8);
      u_host.wr(8'h08, 16'h0008);
      rdchk(8'h08, 16'h0008);
      cyc(30);
      u_host.wr(8'h08, 16'h0008);
      rdchk(8'h08, 16'h0000);
      u_host.wr(8'h04, 16'h0001);
      cyc(4);
      chk(16'(dc), 16'h0000);
      cyc(250);
      chk(16'(dc), 16'h0001);
      u_host.wr(8'h04, 16'h0002);
      u_host.wr(8'h10, 16'h0007);
   endtask : t_pf
   task t_pins;
      for (int k = 0; k < 3; k++)
      begin
         @(posedge clk_sys_in) hw[k == 0 ? 1 : 5 - k] <= 1'b1;
         cyc(10);
         chk(16'(an), 16'(k == 0));
         rdchk(8'h08, k ? 16'h0040 : 16'h0010);
         @(posedge clk_sys_in) hw[k == 0 ? 1 : 5 - k] <= 1'b0;
         cyc(8);
         u_host.wr(8'h08, 16'h00FF);
         rdchk(8'h08, 16'h0000);
      end
      u_host.wr(8'h00, 16'h0003);
      @(posedge clk_sys_in) hw[2] <= 1'b1;
      cyc(10);
      @(posedge clk_sys_in) hw[2] <= 1'b0;
      cyc(8);
      u_host.wr(8'h08, 16'h00FF);
      rdchk(8'h08, 16'h0020);
      u_host.wr(8'h04, 16'h0004);
      rdchk(8'h08, 16'h0000);
   endtask : t_pins
   task tally_and_finish;
      $display("mismatches %0d compares %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      repeat (16) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      rdchk(8'h00, 16'h0001);
      rdchk(8'h2C, 16'h0000);
      rdchk(8'h20, 16'hFFFF);
      rdchk(8'hFC, 16'h0000);
      t_prot();
      t_evt();
      t_pf();
      t_pins();
      tally_and_finish();
   end
   initial
   begin
      #100000;
      mismatches++;
      tally_and_finish();
   end
endmodule : aes_supervisor_tb
